// *** logic/adc_out_defines.svh ***
// Constants for the converter output block: widths, limits, counts.
// Assumes inclusion by the package and the design modules only.
`ifndef ADC_OUT_DEFINES_SVH
`define ADC_OUT_DEFINES_SVH

`define ADC_WORD_W        16
`define ADC_IN_W          20
`define ADC_DECIM_RATIO   16
`define ADC_DECIM_SHIFT   4
`define ADC_PHASE_W       4
`define ADC_SETTLE_WORDS  51
`define ADC_SETTLE_W      6
`define ADC_BIT_CNT_W     4
`define ADC_POS_FULL      16'h7FFF
`define ADC_NEG_FULL      16'h8000
`define ADC_WORD_ZERO     16'h0000

`endif

// *** logic/adc_out_pkg.sv ***
// Types shared by the converter output block.
// Assumes the defines header sits beside it.
`include "adc_out_defines.svh"

package adc_out_pkg;

  typedef enum logic [1:0] {
    AWAIT_ALIGN,
    ALIGNING,
    SETTLING,
    RUNNING
  } core_state_t;

  typedef enum logic {
    LINK_IDLE,
    LINK_SHIFT
  } link_state_t;

  typedef logic [`ADC_WORD_W-1:0] word_t;

endpackage

// *** logic/sync_2ff.sv ***
// Two-flop level synchroniser into the clock given on clk.
// Assumes d is a level that stays put for several clk periods.
`timescale 1ns/1ps

module sync_2ff (
  input  wire logic clk,
  input  wire logic d,
  output logic      q
);

  logic meta_reg;
  logic q_reg;

  // First flop feeds only the second one
  always_ff @(posedge clk) begin
    meta_reg <= d;
    q_reg    <= meta_reg;
  end

  assign q = q_reg;

endmodule

// *** logic/decim_filter.sv ***
// Decimating averager: sums RATIO modulator samples, emits one mean.
// Assumes one signed sample per clk from logic on the same clock.
`timescale 1ns/1ps
`include "adc_out_defines.svh"

module decim_filter #(
  parameter int IN_W  = `ADC_IN_W,
  parameter int RATIO = `ADC_DECIM_RATIO,
  parameter int SHIFT = `ADC_DECIM_SHIFT,
  parameter int PH_W  = `ADC_PHASE_W
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   phase_clear,
  input  wire logic signed [IN_W-1:0] sample,
  output logic signed [IN_W-1:0]      mean,
  output logic                        mean_valid
);

  localparam int ACC_W = IN_W + SHIFT;

  logic        [PH_W-1:0]  phase_reg;
  logic signed [ACC_W-1:0] acc_reg;
  logic signed [IN_W-1:0]  mean_reg;
  logic                    valid_reg;

  wire last_phase = (phase_reg == PH_W'(RATIO - 1));
  wire signed [ACC_W-1:0] sample_ext = ACC_W'(sample);
  wire signed [ACC_W-1:0] acc_sum    = acc_reg + sample_ext;

  // Phase restarts on alignment so aligned parts decimate in step
  always_ff @(posedge clk) begin
    if (rst || phase_clear) begin
      phase_reg <= '0;
      acc_reg   <= '0;
      valid_reg <= 1'b0;
    end else begin
      phase_reg <= last_phase ? '0 : phase_reg + PH_W'(1);
      acc_reg   <= last_phase ? '0 : acc_sum;
      valid_reg <= last_phase;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mean_reg <= '0;
    end else if (last_phase && !phase_clear) begin
      mean_reg <= IN_W'(acc_sum >>> SHIFT);
    end
  end

  assign mean       = mean_reg;
  assign mean_valid = valid_reg;

endmodule

// *** logic/adc_serial_output_sync.sv ***
// Converter output side: decimation, clipping, alignment, serial master.
// Assumes mod_sample comes from modulator logic on core_clk, while
// align_in and sleep_request_n are pins; ser_clk is the link clock.
`timescale 1ns/1ps
`include "adc_out_defines.svh"

module adc_serial_output_sync #(
  parameter int IN_W         = `ADC_IN_W,
  parameter int WORD_W       = `ADC_WORD_W,
  parameter int DECIM_RATIO  = `ADC_DECIM_RATIO,
  parameter int DECIM_SHIFT  = `ADC_DECIM_SHIFT,
  parameter int SETTLE_WORDS = `ADC_SETTLE_WORDS
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   ser_clk,
  input  wire logic                   align_in,
  input  wire logic                   sleep_request_n,
  input  wire logic signed [IN_W-1:0] mod_sample,
  output logic                        frame_sync_out,
  output logic                        frame_sync_out_n,
  output logic                        bit_clk,
  output logic                        bit_clk_n,
  output logic                        ser_data,
  output logic                        ser_data_n,
  output logic                        out_of_range_flag
);

  localparam int SET_W = `ADC_SETTLE_W;
  localparam int BIT_W = `ADC_BIT_CNT_W;

  // Clip to the signed word range; bit WORD_W is the out-of-range mark
  function automatic logic [WORD_W:0] clip_word(
    input logic signed [IN_W-1:0] v
  );
    logic signed [IN_W-1:0] pos_lim;
    logic signed [IN_W-1:0] neg_lim;
    pos_lim = IN_W'($signed(`ADC_POS_FULL));
    neg_lim = -IN_W'($signed({1'b0, `ADC_NEG_FULL}));
    if (v > pos_lim) begin
      clip_word = {1'b1, `ADC_POS_FULL};
    end else if (v < neg_lim) begin
      clip_word = {1'b1, `ADC_NEG_FULL};
    end else begin
      clip_word = {1'b0, v[WORD_W-1:0]};
    end
  endfunction

  // Core domain: pins brought in, filter, alignment sequencing

  logic align_s;
  logic sleep_n_s;

  sync_2ff u_sync_align (
    .clk (core_clk),
    .d   (align_in),
    .q   (align_s)
  );

  sync_2ff u_sync_sleep (
    .clk (core_clk),
    .d   (sleep_request_n),
    .q   (sleep_n_s)
  );

  logic signed [IN_W-1:0] mean;
  logic                   mean_valid;

  // Filter runs off core_clk alone, so its response tracks that clock
  decim_filter #(
    .IN_W  (IN_W),
    .RATIO (DECIM_RATIO),
    .SHIFT (DECIM_SHIFT),
    .PH_W  (`ADC_PHASE_W)
  ) u_filter (
    .clk         (core_clk),
    .rst         (rst),
    .phase_clear (align_s),
    .sample      (mod_sample),
    .mean        (mean),
    .mean_valid  (mean_valid)
  );

  adc_out_pkg::core_state_t state_reg;
  adc_out_pkg::core_state_t state_next;

  logic [SET_W-1:0]    settle_reg;
  logic [SET_W-1:0]    settle_next;
  adc_out_pkg::word_t  hold_word_reg;
  logic                hold_otr_reg;
  logic                req_tog_reg;
  logic                link_hold_reg;

  wire [WORD_W:0] clipped   = clip_word(mean);
  wire            settled   = (settle_reg == SET_W'(SETTLE_WORDS - 1));
  // Nothing handed over once alignment is seen, so no word races it
  wire            send_word = (state_reg == adc_out_pkg::RUNNING)
                              && mean_valid && !align_s
                              && sleep_n_s;

  // Alignment restarts everything; sleep never drops back to waiting
  always_comb begin
    state_next  = state_reg;
    settle_next = settle_reg;
    case (state_reg)
      adc_out_pkg::AWAIT_ALIGN: begin
        if (align_s) begin
          state_next = adc_out_pkg::ALIGNING;
        end
      end
      adc_out_pkg::ALIGNING: begin
        settle_next = '0;
        if (!align_s) begin
          state_next = adc_out_pkg::SETTLING;
        end
      end
      adc_out_pkg::SETTLING: begin
        if (align_s) begin
          state_next = adc_out_pkg::ALIGNING;
        end else if (mean_valid) begin
          if (settled) begin
            state_next = adc_out_pkg::RUNNING;
          end else begin
            settle_next = settle_reg + SET_W'(1);
          end
        end
      end
      adc_out_pkg::RUNNING: begin
        if (align_s) begin
          state_next = adc_out_pkg::ALIGNING;
        end
      end
      default: begin
        state_next = adc_out_pkg::AWAIT_ALIGN;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg  <= adc_out_pkg::AWAIT_ALIGN;
      settle_reg <= '0;
    end else begin
      state_reg  <= state_next;
      settle_reg <= settle_next;
    end
  end

  // Frames barred from alignment to the end of settling; registered
  // so the link can take it through two flops
  wire hold_link = (state_next == adc_out_pkg::ALIGNING)
                   || (state_next == adc_out_pkg::SETTLING);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      link_hold_reg <= 1'b0;
    end else begin
      link_hold_reg <= hold_link;
    end
  end

  // Word held steady for a whole decimation period after each toggle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hold_word_reg <= `ADC_WORD_ZERO;
      hold_otr_reg  <= 1'b0;
      req_tog_reg   <= 1'b0;
    end else if (send_word) begin
      hold_word_reg <= clipped[WORD_W-1:0];
      hold_otr_reg  <= clipped[WORD_W];
      req_tog_reg   <= ~req_tog_reg;
    end
  end

  // Link domain: runs on ser_clk; bit_clk is its inverse

  logic link_rst;
  logic req_tog_s;
  logic hold_s;

  // Link reset lags core reset by two link clocks
  sync_2ff u_sync_rst (
    .clk (ser_clk),
    .d   (rst),
    .q   (link_rst)
  );

  sync_2ff u_sync_req (
    .clk (ser_clk),
    .d   (req_tog_reg),
    .q   (req_tog_s)
  );

  // Settling spans many words, so a plain level sync is enough
  sync_2ff u_sync_hold (
    .clk (ser_clk),
    .d   (link_hold_reg),
    .q   (hold_s)
  );

  adc_out_pkg::link_state_t lstate_reg;
  adc_out_pkg::link_state_t lstate_next;

  logic               req_seen_reg;
  logic               pend_reg;
  adc_out_pkg::word_t pend_word_reg;
  logic               pend_otr_reg;
  adc_out_pkg::word_t shift_reg;
  logic [BIT_W-1:0]   bit_cnt_reg;
  logic               fs_reg;
  logic               fs_n_reg;
  logic               data_reg;
  logic               data_n_reg;
  logic               otr_reg;

  wire new_word    = (req_tog_s != req_seen_reg);
  wire last_bit    = (bit_cnt_reg == BIT_W'(WORD_W - 1));
  wire frame_end   = (lstate_reg == adc_out_pkg::LINK_SHIFT) && last_bit;
  wire link_idle   = (lstate_reg == adc_out_pkg::LINK_IDLE);
  // Stale words held back so a short pulse cannot leak old frames
  wire frame_start = pend_reg && (link_idle || frame_end)
                     && !hold_s;

  // Words arriving mid-frame overwrite the pending one: newest wins
  always_ff @(posedge ser_clk) begin
    if (link_rst) begin
      req_seen_reg  <= 1'b0;
      pend_reg      <= 1'b0;
      pend_word_reg <= `ADC_WORD_ZERO;
      pend_otr_reg  <= 1'b0;
    end else begin
      req_seen_reg <= req_tog_s;
      if (hold_s) begin
        pend_reg <= 1'b0;
      end else if (new_word) begin
        pend_reg      <= 1'b1;
        pend_word_reg <= hold_word_reg;
        pend_otr_reg  <= hold_otr_reg;
      end else if (frame_start) begin
        pend_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    lstate_next = lstate_reg;
    case (lstate_reg)
      adc_out_pkg::LINK_IDLE: begin
        if (frame_start) begin
          lstate_next = adc_out_pkg::LINK_SHIFT;
        end
      end
      adc_out_pkg::LINK_SHIFT: begin
        if (last_bit && !frame_start) begin
          lstate_next = adc_out_pkg::LINK_IDLE;
        end
      end
      default: begin
        lstate_next = adc_out_pkg::LINK_IDLE;
      end
    endcase
  end

  // Rising ser_clk is the falling edge of bit_clk
  always_ff @(posedge ser_clk) begin
    if (link_rst) begin
      lstate_reg  <= adc_out_pkg::LINK_IDLE;
      bit_cnt_reg <= '0;
      shift_reg   <= `ADC_WORD_ZERO;
    end else begin
      lstate_reg <= lstate_next;
      if (frame_start) begin
        bit_cnt_reg <= '0;
        shift_reg   <= pend_word_reg;
      end else if (!link_idle) begin
        bit_cnt_reg <= bit_cnt_reg + BIT_W'(1);
        shift_reg   <= {shift_reg[WORD_W-2:0], 1'b0};
      end
    end
  end

  // Data between frames rests low, its copy high
  wire next_data = frame_start ? pend_word_reg[WORD_W-1]
                               : shift_reg[WORD_W-2];
  wire next_live = frame_start || (!link_idle && !last_bit);
  wire next_bit  = next_live && next_data;

  // Outputs registered so they move only on bit_clk falling edges
  always_ff @(posedge ser_clk) begin
    if (link_rst) begin
      fs_reg     <= 1'b0;
      fs_n_reg   <= 1'b1;
      data_reg   <= 1'b0;
      data_n_reg <= 1'b1;
    end else begin
      fs_reg     <= frame_start;
      fs_n_reg   <= ~frame_start;
      data_reg   <= next_bit;
      data_n_reg <= ~next_bit;
    end
  end

  // Flag follows its word, so it only moves at a frame start
  always_ff @(posedge ser_clk) begin
    if (link_rst) begin
      otr_reg <= 1'b0;
    end else if (frame_start) begin
      otr_reg <= pend_otr_reg;
    end
  end

  // Bit clock is the link clock itself, inverted for the receiver
  assign bit_clk           = ~ser_clk;
  assign bit_clk_n         = ser_clk;
  assign frame_sync_out    = fs_reg;
  assign frame_sync_out_n  = fs_n_reg;
  assign ser_data          = data_reg;
  assign ser_data_n        = data_n_reg;
  assign out_of_range_flag = otr_reg;

endmodule

// *** bench/adc_out_checker.sv ***
// Checker: timing relations seen at the output block's pins.
// Assumes a bind onto adc_serial_output_sync, ports by name.
`timescale 1ns/1ps

module adc_out_checker #(
  parameter int SETTLE_WORDS = 51
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ser_clk,
  input wire logic align_in,
  input wire logic frame_sync_out,
  input wire logic frame_sync_out_n,
  input wire logic bit_clk,
  input wire logic bit_clk_n,
  input wire logic ser_data,
  input wire logic ser_data_n,
  input wire logic out_of_range_flag
);
  int   since_reg;
  logic seen_reg;

  // Cycles since alignment release, saturating
  always_ff @(posedge core_clk) begin
    if (rst || align_in) since_reg <= 0;
    else if (since_reg < 4095) since_reg <= since_reg + 1;
  end

  always_ff @(posedge core_clk) begin
    if (rst || align_in) seen_reg <= 1'b0;
    else if (frame_sync_out) seen_reg <= 1'b1;
  end

  sequence quiet_s;
    !frame_sync_out [*8] ##1 !frame_sync_out [*7];
  endsequence

  clk_copy_a: assert property (@(posedge core_clk) disable iff (rst)
    bit_clk == !ser_clk && bit_clk_n == ser_clk)
    else $error("bit clock copies wrong");
  sync_copy_a: assert property (@(negedge ser_clk) disable iff (rst)
    frame_sync_out_n == !frame_sync_out) else $error("sync copy wrong");
  data_copy_a: assert property (@(negedge ser_clk) disable iff (rst)
    ser_data_n == !ser_data) else $error("data copy wrong");
  frame_gap_a: assert property (@(posedge ser_clk) disable iff (rst)
    $rose(frame_sync_out) |=> quiet_s) else $error("frame too short");
  flag_edge_a: assert property (@(posedge ser_clk) disable iff (rst)
    $changed(out_of_range_flag) |-> frame_sync_out)
    else $error("flag moved mid frame");
  settle_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
    since_reg > 40 && since_reg < SETTLE_WORDS * 16 |-> !frame_sync_out)
    else $error("frame during settling");
  first_frame_a: assert property (@(posedge core_clk) disable iff (rst)
    since_reg == SETTLE_WORDS * 16 + 120 |-> seen_reg)
    else $error("no frame after settling");
  reset_idle_a: assert property (@(posedge core_clk)
    rst [*6] |-> !frame_sync_out && !ser_data && !out_of_range_flag)
    else $error("outputs busy in reset");
endmodule

// *** bench/frame_receiver.sv ***
// Receiving serial port model: shifts one frame in on bit clock rise.
// Assumes the output block masters both frame sync and bit clock.
`timescale 1ns/1ps

module frame_receiver (
  input  wire logic        bit_clk,
  input  wire logic        frame_sync_out,
  input  wire logic        ser_data,
  input  wire logic        out_of_range_flag,
  output logic [16:0]      rx_word,
  output logic             rx_valid
);
  logic [15:0] shift_reg;
  int          count_reg = 16;
  logic        flag_reg;

  // Opposite edge to the launch, so data is mid-bit here
  always_ff @(posedge bit_clk) begin
    rx_valid <= 1'b0;
    if (frame_sync_out) begin
      shift_reg <= {15'h0000, ser_data};
      count_reg <= 1;
      flag_reg  <= out_of_range_flag;
    end else if (count_reg < 16) begin
      shift_reg <= {shift_reg[14:0], ser_data};
      count_reg <= count_reg + 1;
      if (count_reg == 15) begin
        rx_word  <= {flag_reg, shift_reg[14:0], ser_data};
        rx_valid <= 1'b1;
      end
    end
  end
endmodule

// *** bench/adc_serial_output_sync_bench.sv ***
// Bench: steady samples per segment, frames checked against notes.
// Assumes the design, the receiver model and the checker compiled.
`timescale 1ns/1ps

module adc_serial_output_sync_bench;
  logic               core_clk = 1'b0;
  logic               ser_clk = 1'b0;
  logic               rst = 1'b1;
  logic               align_in = 1'b0;
  logic               sleep_request_n = 1'b1;
  logic signed [19:0] mod_sample = 20'sh00000;
  logic               fs, fs_n, bclk, bclk_n, sd, sd_n, flag, rx_valid;
  logic [16:0]        rx_word, note;
  logic [16:0]        notes[$];
  int                 n_errors = 0;
  int                 checks = 0;
  int                 t;
  integer             seed = 32'h9658C26E;
  localparam logic signed [19:0] VALS [8] = '{20'sh00000, 20'sh00001,
    -20'sh00001, 20'sh07FFF, 20'sh08000, 20'sh0A000, -20'sh08000,
    -20'sh08001};

  initial forever #5 core_clk = ~core_clk;
  initial begin
    #2;
    forever #6 ser_clk = ~ser_clk;
  end

  adc_serial_output_sync #(.SETTLE_WORDS(4)) u_dut (
    .core_clk(core_clk), .rst(rst), .ser_clk(ser_clk),
    .align_in(align_in), .sleep_request_n(sleep_request_n),
    .mod_sample(mod_sample), .frame_sync_out(fs),
    .frame_sync_out_n(fs_n), .bit_clk(bclk), .bit_clk_n(bclk_n),
    .ser_data(sd), .ser_data_n(sd_n), .out_of_range_flag(flag));

  frame_receiver u_rx (
    .bit_clk(bclk), .frame_sync_out(fs), .ser_data(sd),
    .out_of_range_flag(flag), .rx_word(rx_word), .rx_valid(rx_valid));

  task automatic conclude();
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [16:0] exp, got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [16:0] exp_of(input logic signed [19:0] v);
    if (v > 20'sh07FFF) return {1'b1, 16'h7FFF};
    if (v < -20'sh08000) return {1'b1, 16'h8000};
    return {1'b0, v[15:0]};
  endfunction

  // Held long so no word from before the pulse is still in flight
  task automatic align();
    @(negedge core_clk);
    align_in = 1'b1;
    tick(30);
    @(negedge core_clk);
    align_in = 1'b0;
    t = 0;
    while (fs !== 1'b1 && t < 300) begin
      tick(1);
      t++;
    end
    if (t == 300) begin
      n_errors++;
      conclude();
    end
    check("settle", 17'(t >= 64 && t <= 140), 17'h00001);
  endtask

  // Wait out mixed words and the link delay before noting the result
  task automatic segment(input logic signed [19:0] v);
    mod_sample = v;
    tick(80);
    notes.push_back(exp_of(v));
    t = 0;
    while (notes.size() > 0 && t < 100) begin
      tick(1);
      t++;
    end
    if (t == 100) begin
      n_errors++;
      conclude();
    end
  endtask

  always @(posedge bclk) begin
    if (rx_valid === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      check("frame", note, rx_word);
    end
  end

  initial begin
    tick(6);
    rst = 1'b0;
    tick(1);
    align();
    foreach (VALS[i]) segment(VALS[i]);
    repeat (6) segment(20'($random(seed)));
    sleep_request_n = 1'b0;
    tick(30);
    t = 0;
    repeat (150) begin
      tick(1);
      if (fs === 1'b1) t++;
    end
    check("sleep", 17'(t), 17'h00000);
    sleep_request_n = 1'b1;
    // Data after wake ignored for 100 conversions of 16 clocks
    tick(100 * 16);
    segment(20'sh00123);
    align();
    segment(-20'sh00042);
    conclude();
  end
endmodule

bind adc_serial_output_sync adc_out_checker #(
  .SETTLE_WORDS(SETTLE_WORDS)
) u_chk (
  .core_clk(core_clk), .rst(rst), .ser_clk(ser_clk),
  .align_in(align_in), .frame_sync_out(frame_sync_out),
  .frame_sync_out_n(frame_sync_out_n), .bit_clk(bit_clk),
  .bit_clk_n(bit_clk_n), .ser_data(ser_data), .ser_data_n(ser_data_n),
  .out_of_range_flag(out_of_range_flag));
